/* pkg/cpid_pkg.sv */
package cpid_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the ahb-lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_REFUSE_CNT = 8'h04;
  localparam logic [7:0] REG_USER_ID0   = 8'h10;
  localparam logic [7:0] REG_USER_ID3   = 8'h1c;
  localparam logic [7:0] REG_IDENTITY   = 8'h20;

  // status field positions
  localparam int ST_PROG_LOCK_N   = 0;
  localparam int ST_EEPROM_LOCK_N = 1;
  localparam int ST_GUARD_LSB     = 2;
  localparam int ST_CAPTURED      = 4;

  // ----------------------------------------------------------------
  // access-port address space
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_USER_ID0  = 16'h8000;
  localparam logic [15:0] ADDR_IDENTITY  = 16'h8006;
  localparam int          CFG_SPACE_BIT  = 15;

  // identity word layout
  localparam int          ID_PART_LSB    = 5;
  localparam int          ID_REV_LSB     = 0;
  localparam logic [1:0]  ID_UPPER_BITS  = 2'h3;

  // self-write guard range encodings and limits
  localparam logic [1:0]  GUARD_OFF      = 2'h3;
  localparam logic [1:0]  GUARD_BOOT     = 2'h2;
  localparam logic [1:0]  GUARD_HALF     = 2'h1;
  localparam logic [1:0]  GUARD_ALL      = 2'h0;
  localparam logic [12:0] GUARD_BOOT_TOP = 13'h01ff;
  localparam logic [12:0] GUARD_HALF_TOP = 13'h0fff;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic       RST_LOCK_N     = 1'b0;
  localparam logic [1:0] RST_GUARD      = GUARD_ALL;
  localparam logic [1:0] CAPTURE_CYCLES = 2'h2;
  localparam logic [15:0] RST_WORD      = 16'h0000;

endpackage

/* verilog/cpid_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for quasi-static levels
module cpid_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* verilog/cpid_guard.sv */
`timescale 1ns/1ps
`default_nettype none

// decides whether a program address lies in the self-write shield
module cpid_guard
  import cpid_pkg::*;
(
  input  wire logic [1:0]  range,
  input  wire logic [12:0] addr,
  output var  logic        hit
);

  // ----------------------------------------------------------------
  // shield always starts at address zero
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    if (range == GUARD_OFF) begin
      hit = 1'b0;
    end else if (range == GUARD_BOOT) begin
      hit = (addr <= GUARD_BOOT_TOP);
    end else if (range == GUARD_HALF) begin
      hit = (addr <= GUARD_HALF_TOP);
    end
  end

endmodule

`default_nettype wire

/* verilog/cpid_top.sv */
// Function
// - program memory and eeprom each have their own external lock
// - cpu accesses ignore both external lock settings
// - program lock active: external writes dropped, reads return zero
// - cpu reads program memory freely; writes checked only by guard range
// - eeprom lock active: every external eeprom read and write refused
// - cpu reads and writes eeprom regardless of eeprom lock
// - two-bit guard range shields a block from address zero
// - 11 none, 10 to 1ffh, 01 to fffh, 00 whole memory
// - erase that lifts program lock erases all program memory
// - four user id words at 8000h-8003h, readable and writable
// - identity word at 8006h: part code 13:5, revision 4:0
// - identity bits 15 and 14 always read one
// - writes to the identity word are ignored
// - external tools may read the identity word
`timescale 1ns/1ps
`default_nettype none

module cpid_top #(
  parameter logic [8:0] PART_CODE = 9'h155, // arbitrary value
  parameter logic [4:0] REV_CODE  = 5'h01   // arbitrary value
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        cfg_prog_lock_n,
  input  wire logic        cfg_eeprom_lock_n,
  input  wire logic [1:0]  cfg_guard_range,
  input  wire logic        ext_req,
  input  wire logic        ext_we,
  input  wire logic        ext_eeprom,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  input  wire logic        ext_erase,
  input  wire logic        ext_erase_prog_lock_n,
  input  wire logic        ext_erase_eeprom_lock_n,
  output var  logic        ext_ack,
  output var  logic        ext_refused,
  output var  logic [15:0] ext_rdata,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic        cpu_eeprom,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output var  logic        cpu_ack,
  output var  logic        cpu_refused,
  output var  logic [15:0] cpu_rdata,
  output var  logic        mem_req,
  output var  logic        mem_we,
  output var  logic        mem_eeprom,
  output var  logic [15:0] mem_addr,
  output var  logic [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  output var  logic        prog_erase,
  output var  logic        eeprom_erase
);

  import cpid_pkg::*;
  localparam logic [15:0] IDENTITY_WORD = {ID_UPPER_BITS, PART_CODE, REV_CODE};
  logic [3:0]  cfg_sync;
  logic [1:0]  cap_cnt_q;
  logic        captured_q;
  logic        prog_lock_n_q;
  logic        eeprom_lock_n_q;
  logic [1:0]  guard_q;
  logic [15:0] user_id_q [4];
  logic [15:0] refuse_cnt_q;
  logic        ext_pend_q;
  logic        ext_we_h_q;
  logic        ext_eeprom_h_q;
  logic [15:0] ext_addr_h_q;
  logic [15:0] ext_wdata_h_q;
  logic        s1_valid_q;
  logic        s1_cpu_q;
  logic        s1_mem_q;
  logic        s1_ref_q;
  logic [15:0] s1_data_q;
  logic        s2_valid_q;
  logic        s2_cpu_q;
  logic        s2_mem_q;
  logic        s2_ref_q;
  logic [15:0] s2_data_q;
  logic        ahb_we_q;
  logic [7:0]  ahb_addr_q;

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  cpid_sync #(.WIDTH (4)) u_cfg_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({cfg_guard_range, cfg_eeprom_lock_n, cfg_prog_lock_n}),
    .q       (cfg_sync)
  );

  // locks sit in their safe state until the synchroniser has filled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_cnt_q       <= '0;
      captured_q      <= 1'b0;
      prog_lock_n_q   <= RST_LOCK_N;
      eeprom_lock_n_q <= RST_LOCK_N;
      guard_q         <= RST_GUARD;
    end else if (!captured_q) begin
      if (cap_cnt_q == CAPTURE_CYCLES) begin
        captured_q      <= 1'b1;
        prog_lock_n_q   <= cfg_sync[0];
        eeprom_lock_n_q <= cfg_sync[1];
        guard_q         <= cfg_sync[3:2];
      end else begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
      end
    end else if (ext_erase) begin
      // an erase installs the new lock values it carries
      prog_lock_n_q   <= ext_erase_prog_lock_n;
      eeprom_lock_n_q <= ext_erase_eeprom_lock_n;
    end
  end

  // ----------------------------------------------------------------
  // bulk erase on unlock
  // ----------------------------------------------------------------
  // unlocking never exposes old contents: the array is wiped first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_erase   <= 1'b0;
      eeprom_erase <= 1'b0;
    end else begin
      prog_erase   <= captured_q && ext_erase && !prog_lock_n_q && ext_erase_prog_lock_n;
      eeprom_erase <= captured_q && ext_erase && !eeprom_lock_n_q && ext_erase_eeprom_lock_n;
    end
  end

  // ----------------------------------------------------------------
  // external request holding register
  // ----------------------------------------------------------------
  // the cpu wins a shared cycle; the external request waits here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_pend_q     <= 1'b0;
      ext_we_h_q     <= 1'b0;
      ext_eeprom_h_q <= 1'b0;
      ext_addr_h_q   <= RST_WORD;
      ext_wdata_h_q  <= RST_WORD;
    end else if (ext_req) begin
      ext_pend_q     <= 1'b1;
      ext_we_h_q     <= ext_we;
      ext_eeprom_h_q <= ext_eeprom;
      ext_addr_h_q   <= ext_addr;
      ext_wdata_h_q  <= ext_wdata;
    end else if (!cpu_req) begin
      ext_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------
  logic        go;
  logic        is_ext;
  logic        a_we;
  logic        a_eep;
  logic [15:0] a_addr;
  logic [15:0] a_wdata;
  logic        a_cfg;
  logic        a_uid;
  logic        guard_hit;
  logic        allow;
  logic [15:0] local_data;

  assign is_ext  = !cpu_req && ext_pend_q;
  assign go      = cpu_req || is_ext;
  assign a_we    = is_ext ? ext_we_h_q : cpu_we;
  assign a_eep   = is_ext ? ext_eeprom_h_q : cpu_eeprom;
  assign a_addr  = is_ext ? ext_addr_h_q : cpu_addr;
  assign a_wdata = is_ext ? ext_wdata_h_q : cpu_wdata;
  assign a_cfg   = !a_eep && a_addr[CFG_SPACE_BIT];
  assign a_uid   = a_cfg && (a_addr[15:2] == ADDR_USER_ID0[15:2]);

  cpid_guard u_guard (
    .range (guard_q),
    .addr  (a_addr[12:0]),
    .hit   (guard_hit)
  );

  // protection check; configuration space is open to both parties
  always_comb begin
    allow = 1'b1;
    if (a_eep) begin
      allow = !is_ext || eeprom_lock_n_q;
    end else if (is_ext && !a_cfg) begin
      allow = prog_lock_n_q;
    end else if (!a_cfg) begin
      allow = !a_we || !guard_hit;
    end
  end

  // data for answers produced here; refused reads give zero
  always_comb begin
    local_data = RST_WORD;
    if (a_uid) begin
      local_data = user_id_q[a_addr[1:0]];
    end else if (a_cfg && a_addr == ADDR_IDENTITY) begin
      local_data = IDENTITY_WORD;
    end
  end

  // ----------------------------------------------------------------
  // answer pipeline: issue, memory data, answer
  // ----------------------------------------------------------------
  // refused or not, cpu accesses answer after three cycles and external ones after four unless held by the cpu
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_valid_q <= 1'b0;
      s1_cpu_q   <= 1'b0;
      s1_mem_q   <= 1'b0;
      s1_ref_q   <= 1'b0;
      s1_data_q  <= RST_WORD;
      s2_valid_q <= 1'b0;
      s2_cpu_q   <= 1'b0;
      s2_mem_q   <= 1'b0;
      s2_ref_q   <= 1'b0;
      s2_data_q  <= RST_WORD;
    end else begin
      s1_valid_q <= go;
      s1_cpu_q   <= !is_ext;
      s1_mem_q   <= allow && !a_cfg;
      s1_ref_q   <= !allow;
      s1_data_q  <= (allow && !a_we) ? local_data : RST_WORD;
      s2_valid_q <= s1_valid_q;
      s2_cpu_q   <= s1_cpu_q;
      s2_mem_q   <= s1_mem_q && !mem_we;
      s2_ref_q   <= s1_ref_q;
      s2_data_q  <= s1_data_q;
    end
  end

  // memory strobes only for allowed accesses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_eeprom <= 1'b0;
      mem_addr   <= RST_WORD;
      mem_wdata  <= RST_WORD;
    end else begin
      mem_req    <= go && allow && !a_cfg;
      mem_we     <= go && allow && !a_cfg && a_we;
      mem_eeprom <= a_eep;
      mem_addr   <= a_addr;
      mem_wdata  <= a_wdata;
    end
  end

  // answer registers, one-cycle acks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_ack     <= 1'b0;
      cpu_refused <= 1'b0;
      cpu_rdata   <= RST_WORD;
      ext_ack     <= 1'b0;
      ext_refused <= 1'b0;
      ext_rdata   <= RST_WORD;
    end else begin
      cpu_ack <= s2_valid_q && s2_cpu_q;
      ext_ack <= s2_valid_q && !s2_cpu_q;
      if (s2_valid_q && s2_cpu_q) begin
        cpu_refused <= s2_ref_q;
        cpu_rdata   <= s2_mem_q ? mem_rdata : s2_data_q;
      end
      if (s2_valid_q && !s2_cpu_q) begin
        ext_refused <= s2_ref_q;
        ext_rdata   <= s2_mem_q ? mem_rdata : s2_data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  logic        ahb_take;
  logic [31:0] rd_word;

  assign ahb_take = hsel && htrans[1] && hready;

  // read data is formed in the address phase so hrdata is a flop
  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[7:0] == REG_STATUS) begin
      rd_word[ST_PROG_LOCK_N]              = prog_lock_n_q;
      rd_word[ST_EEPROM_LOCK_N]            = eeprom_lock_n_q;
      rd_word[ST_GUARD_LSB+1:ST_GUARD_LSB] = guard_q;
      rd_word[ST_CAPTURED]                 = captured_q;
    end else if (haddr[7:0] == REG_REFUSE_CNT) begin
      rd_word[15:0] = refuse_cnt_q;
    end else if (haddr[7:0] >= REG_USER_ID0 && haddr[7:0] <= REG_USER_ID3) begin
      rd_word[15:0] = user_id_q[haddr[3:2]];
    end else if (haddr[7:0] == REG_IDENTITY) begin
      rd_word[15:0] = IDENTITY_WORD;
    end
    if (haddr[31:8] != 24'h000000 || haddr[1:0] != 2'h0) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      ahb_we_q   <= 1'b0;
      ahb_addr_q <= 8'h00;
    end else begin
      ahb_we_q  <= ahb_take && hwrite && haddr[31:8] == 24'h000000;
      if (ahb_take) begin
        ahb_addr_q <= haddr[7:0];
        hrdata     <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // user id words and refusal counter
  // ----------------------------------------------------------------
  // port writes are applied after bus writes so they win a collision
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        user_id_q[i] <= RST_WORD;
      end
    end else begin
      if (ahb_we_q && ahb_addr_q >= REG_USER_ID0 && ahb_addr_q <= REG_USER_ID3
          && ahb_addr_q[1:0] == 2'h0) begin
        user_id_q[ahb_addr_q[3:2]] <= hwdata[15:0];
      end
      if (go && a_we && a_uid) begin
        user_id_q[a_addr[1:0]] <= a_wdata;
      end
    end
  end

  // a bus write to the counter clears it; a refusal in the same cycle still counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refuse_cnt_q <= RST_WORD;
    end else if (go && is_ext && !allow) begin
      refuse_cnt_q <= (ahb_we_q && ahb_addr_q == REG_REFUSE_CNT)
                      ? 16'h0001 : refuse_cnt_q + 16'h0001;
    end else if (ahb_we_q && ahb_addr_q == REG_REFUSE_CNT) begin
      refuse_cnt_q <= RST_WORD;
    end
  end

endmodule

`default_nettype wire

/* bench/cpid_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port checker for cpid_top
// ------------------------------------------------
module cpid_checker
  import cpid_pkg::*;
#(
  parameter logic [8:0] PART_CODE = 9'h155,
  parameter logic [4:0] REV_CODE  = 5'h01
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        cfg_prog_lock_n,
  input wire logic        cfg_eeprom_lock_n,
  input wire logic [1:0]  cfg_guard_range,
  input wire logic        ext_req,
  input wire logic        ext_we,
  input wire logic        ext_eeprom,
  input wire logic [15:0] ext_addr,
  input wire logic        ext_erase,
  input wire logic        ext_erase_prog_lock_n,
  input wire logic        ext_erase_eeprom_lock_n,
  input wire logic        ext_ack,
  input wire logic        ext_refused,
  input wire logic [15:0] ext_rdata,
  input wire logic        cpu_req,
  input wire logic        cpu_we,
  input wire logic        cpu_eeprom,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_ack,
  input wire logic        cpu_refused,
  input wire logic [15:0] cpu_rdata,
  input wire logic        mem_req,
  input wire logic [15:0] mem_rdata,
  input wire logic        prog_erase
);
  logic       ovr_q;
  logic [1:0] new_q;
  logic       pl_n, el_n, lk, hit, gw, wipe;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // an erase overrides the captured locks until the next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_q <= 1'b0;
      new_q <= 2'h0;
    end else if (ext_erase) begin
      ovr_q <= 1'b1;
      new_q <= {ext_erase_eeprom_lock_n, ext_erase_prog_lock_n};
    end
  end

  // effective locks, shield hit and expected refusals
  assign pl_n = ovr_q ? new_q[0] : cfg_prog_lock_n;
  assign el_n = ovr_q ? new_q[1] : cfg_eeprom_lock_n;
  assign lk   = !ext_addr[15] && (ext_eeprom ? !el_n : !pl_n);
  assign hit  = (cfg_guard_range == GUARD_ALL) ||
                (cfg_guard_range == GUARD_HALF && cpu_addr[12:0] <= GUARD_HALF_TOP) ||
                (cfg_guard_range == GUARD_BOOT && cpu_addr[12:0] <= GUARD_BOOT_TOP);
  assign gw   = cpu_we && !cpu_eeprom && hit;
  assign wipe = !pl_n && ext_erase_prog_lock_n;

  cpu_ack_a: assert property (cpu_req |-> ##3 cpu_ack)
    else $error("cpu ack not three cycles after request");
  cpu_rdata_a: assert property (cpu_req && !cpu_we && !cpu_addr[15]
    |-> ##3 cpu_rdata == $past(mem_rdata)) else $error("cpu read data lost");
  cpu_guard_a: assert property (cpu_req && !cpu_addr[15]
    |-> ##3 cpu_refused == $past(gw, 3)) else $error("cpu refusal wrong");
  ext_lock_a: assert property (ext_req && !ext_addr[15]
    |-> ##4 ext_ack && ext_refused == $past(lk, 4)) else $error("ext refusal wrong");
  ext_zero_a: assert property (ext_req && lk && !ext_eeprom
    |-> ##4 ext_rdata == 16'h0000) else $error("locked read not zero");
  ext_wblock_a: assert property (ext_req && ext_we && lk |=> (!mem_req) [*4])
    else $error("locked write reached memory");
  ident_a: assert property (ext_req && !ext_we && !ext_eeprom
    && ext_addr == ADDR_IDENTITY
    |-> ##4 ext_rdata == {ID_UPPER_BITS, PART_CODE, REV_CODE}) else $error("identity wrong");
  erase_a: assert property (ext_erase |=> prog_erase == $past(wipe))
    else $error("program erase wrong");

  cover property (ext_ack && ext_refused);
  cover property (cpu_ack && cpu_refused);
  cover property (prog_erase);
endmodule
`default_nettype wire

/* bench/cpid_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// program and eeprom array behind the block
// ------------------------------------------------
module cpid_mem_model #(
  parameter logic [15:0] ERASED = 16'hffff
) (
  input  wire logic        hclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_eeprom,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        prog_erase,
  input  wire logic        eeprom_erase,
  output var  logic [15:0] mem_rdata
);
  logic [15:0] pg [256];
  logic [15:0] ee [256];

  // blank arrays at power-up
  initial begin
    foreach (pg[i]) begin
      pg[i] = ERASED;
      ee[i] = ERASED;
    end
    mem_rdata = 16'h0000;
  end

  // data valid one cycle after the request, then toggles so stale data never matches
  always @(posedge hclk) begin
    if (mem_req && !mem_we) begin
      mem_rdata <= mem_eeprom ? ee[mem_addr[7:0]] : pg[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req && mem_we && mem_eeprom) ee[mem_addr[7:0]] <= mem_wdata;
    if (mem_req && mem_we && !mem_eeprom) pg[mem_addr[7:0]] <= mem_wdata;
    foreach (pg[i]) begin
      if (prog_erase) pg[i] <= ERASED;
      if (eeprom_erase) ee[i] <= ERASED;
    end
  end
endmodule
`default_nettype wire

/* bench/code_protect_and_id_access_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// self-checking bench
// ------------------------------------------------
module code_protect_and_id_access_test;
  import cpid_pkg::*;
  localparam logic [8:0]  PART   = 9'h0a7;  // arbitrary value
  localparam logic [4:0]  REV    = 5'h03;   // arbitrary value
  localparam logic [15:0] ERASED = 16'hffff;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0, cfg_guard_range = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        cfg_prog_lock_n = 1'b0, cfg_eeprom_lock_n = 1'b0, ext_erase = 1'b0;
  logic        ext_erase_prog_lock_n = 1'b0, ext_erase_eeprom_lock_n = 1'b0;
  logic        ext_req = 1'b0, ext_we = 1'b0, ext_eeprom = 1'b0, ext_ack, ext_refused;
  logic        cpu_req = 1'b0, cpu_we = 1'b0, cpu_eeprom = 1'b0, cpu_ack, cpu_refused;
  logic [15:0] ext_addr = 16'h0, ext_wdata = 16'h0, cpu_addr = 16'h0, cpu_wdata = 16'h0;
  logic        mem_req, mem_we, mem_eeprom, prog_erase, eeprom_erase;
  logic [15:0] ext_rdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] sb_pg [256];
  logic [15:0] sb_ee [256];
  logic [12:0] edges [6] = '{13'h0000, 13'h01ff, 13'h0200, 13'h0fff, 13'h1000, 13'h1fff};
  int          seed, err_count = 0, tests_run = 0, cycles = 0;

  cpid_top #(.PART_CODE(PART), .REV_CODE(REV)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .cfg_prog_lock_n, .cfg_eeprom_lock_n, .cfg_guard_range,
    .ext_req, .ext_we, .ext_eeprom, .ext_addr, .ext_wdata, .ext_erase, .ext_erase_prog_lock_n,
    .ext_erase_eeprom_lock_n, .ext_ack, .ext_refused, .ext_rdata, .cpu_req, .cpu_we,
    .cpu_eeprom, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_refused, .cpu_rdata, .mem_req,
    .mem_we, .mem_eeprom, .mem_addr, .mem_wdata, .mem_rdata, .prog_erase, .eeprom_erase);
  cpid_mem_model #(.ERASED(ERASED)) u_mem (.hclk, .mem_req, .mem_we, .mem_eeprom,
    .mem_addr, .mem_wdata, .mem_rdata, .prog_erase, .eeprom_erase);

  // 50 mhz clock
  initial begin
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // single ahb-lite word transfer; the slave may stretch either phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // one request on the cpu (c=1) or external port, waits for its ack
  task automatic port_op(input logic c, w, e, input logic [15:0] a, d,
                         output logic [15:0] rd, output logic rf);
    int n;
    @(posedge hclk);
    {cpu_we, ext_we, cpu_eeprom, ext_eeprom} <= {w, w, e, e};
    {cpu_addr, ext_addr, cpu_wdata, ext_wdata} <= {a, a, d, d};
    cpu_req <= c;
    ext_req <= !c;
    @(posedge hclk);
    cpu_req <= 1'b0;
    ext_req <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((c ? cpu_ack : ext_ack) !== 1'b1 && n < 12);
    if (n >= 12) chk(32'h0, 32'h1);
    rd = c ? cpu_rdata : ext_rdata;
    rf = c ? cpu_refused : ext_refused;
  endtask

  function automatic logic hit(input logic [1:0] g, input logic [15:0] a);
    return g == GUARD_ALL || (g == GUARD_HALF && a <= 16'h0fff) ||
           (g == GUARD_BOOT && a <= 16'h01ff);
  endfunction

  // watchdog: a hung handshake ends the run as a failure
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // main sequence: one reset per lock and guard setting
  initial begin
    logic [31:0] r, x;
    logic [15:0] d, v, a;
    logic        c, w, e, rf, xr, pl, el;
    logic [1:0]  gr;
    int          nref;
    seed = 77645;
    foreach (sb_pg[j]) begin
      sb_pg[j] = ERASED;
      sb_ee[j] = ERASED;
    end
    for (int k = 0; k < 4; k++) begin
      {el, pl} = k[1:0];
      gr = ~k[1:0];
      nref = 0;
      @(posedge hclk);
      hresetn <= 1'b0;
      {cfg_eeprom_lock_n, cfg_prog_lock_n, cfg_guard_range} <= {el, pl, gr};
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(1'b0, REG_STATUS, 32'h0, r);
      chk(r, {27'h0, 1'b1, gr, el, pl});
      ahb(1'b1, REG_IDENTITY, 32'h0, r);
      ahb(1'b0, REG_IDENTITY, 32'h0, r);
      chk(r, {16'h0, ID_UPPER_BITS, PART, REV});
      ahb(1'b0, 8'h40, 32'h0, r);
      chk(r, 32'h0);
      d = 16'($random(seed));
      ahb(1'b1, REG_USER_ID0 + 8'h4, {16'h0, d}, r);
      port_op(1'b0, 1'b0, 1'b0, ADDR_USER_ID0 + 16'h1, 16'h0, v, rf);
      chk({15'h0, rf, v}, {16'h0, d});
      port_op(1'b1, 1'b1, 1'b0, ADDR_USER_ID0 + 16'h3, ~d, v, rf);
      ahb(1'b0, REG_USER_ID3, 32'h0, r);
      chk(r, {16'h0, ~d});
      port_op(1'b0, 1'b1, 1'b0, ADDR_IDENTITY, d, v, rf);
      port_op(1'b0, 1'b0, 1'b0, ADDR_IDENTITY, 16'h0, v, rf);
      chk({15'h0, rf, v}, {16'h0, ID_UPPER_BITS, PART, REV});
      for (int i = 0; i < 16; i++) begin
        x = $random(seed);
        {c, w, e} = x[2:0];
        a = {3'h0, (x[5:3] > 3'h5) ? x[28:16] : edges[x[5:3]]};
        d = x[31:16];
        port_op(c, w, e, a, d, v, rf);
        xr = c ? (w && !e && hit(gr, a)) : (e ? !el : !pl);
        chk({31'h0, rf}, {31'h0, xr});
        if (!w) chk({16'h0, v}, {16'h0, xr ? 16'h0 : (e ? sb_ee[a[7:0]] : sb_pg[a[7:0]])});
        if (w && !xr && e) sb_ee[a[7:0]] = d;
        if (w && !xr && !e) sb_pg[a[7:0]] = d;
        nref += int'(!c && xr);
      end
      ahb(1'b0, REG_REFUSE_CNT, 32'h0, r);
      chk(r, nref);
      ahb(1'b1, REG_REFUSE_CNT, 32'h0, r);
      ahb(1'b0, REG_REFUSE_CNT, 32'h0, r);
      chk(r, 32'h0);
      @(posedge hclk);
      {ext_erase, ext_erase_prog_lock_n, ext_erase_eeprom_lock_n} <= 3'h7;
      @(posedge hclk);
      ext_erase <= 1'b0;
      repeat (2) @(posedge hclk);
      foreach (sb_pg[j]) begin
        if (!pl) sb_pg[j] = ERASED;
        if (!el) sb_ee[j] = ERASED;
      end
      port_op(1'b0, 1'b0, 1'b0, 16'h0123, 16'h0, v, rf);
      chk({15'h0, rf, v}, {16'h0, sb_pg[8'h23]});
      port_op(1'b0, 1'b0, 1'b1, 16'h0045, 16'h0, v, rf);
      chk({15'h0, rf, v}, {16'h0, sb_ee[8'h45]});
    end
    give_verdict();
  end
endmodule

bind cpid_top cpid_checker #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) u_chk (
  .hclk, .hresetn, .cfg_prog_lock_n, .cfg_eeprom_lock_n, .cfg_guard_range, .ext_req,
  .ext_we, .ext_eeprom, .ext_addr, .ext_erase, .ext_erase_prog_lock_n,
  .ext_erase_eeprom_lock_n, .ext_ack, .ext_refused, .ext_rdata, .cpu_req, .cpu_we,
  .cpu_eeprom, .cpu_addr, .cpu_ack, .cpu_refused, .cpu_rdata, .mem_req, .mem_rdata,
  .prog_erase);
`default_nettype wire
